// ===== rtl/dpomc_loop.sv
// dpomc_loop: mode control for one loop (automatic machine, forcing, filter stage)
// assumes reference events and lock flag are synchronous to clk_sys_i
module dpomc_loop
   import dpomc_pkg::*;
(
   input  wire logic        clk_sys_i,
   input  wire logic        nrst_i,
   input  wire logic [4:0]  mode_select_i,
   input  wire dpomc_ref_t  ref_i,
   input  wire dpomc_filt_t start_filt_i,
   input  wire dpomc_filt_t acq_filt_i,
   input  wire dpomc_filt_t lock_filt_i,
   input  wire logic        flag_clear_i,
   input  wire logic        irq_mask_i,
   output logic [4:0]       current_mode_report_o,
   output logic             mode_change_flag_o,
   output logic             irq_o,
   output dpomc_stage_t     stage_o,
   output dpomc_filt_t      filt_o,
   output dpomc_ctl_t       ctl_o
);

   dpomc_state_t           state;
   dpomc_state_t           next_state;
   logic [4:0]             next_mode;
   logic                   lock_q;
   logic [START_CNT_W-1:0] start_cnt;
   logic                   lock_rise;
   logic                   lock_fall;

   function automatic logic [4:0] state_code(input dpomc_state_t s);
      case (s)
         DPOMC_ST_FREERUN:   state_code = MODE_FREERUN;
         DPOMC_ST_PRELOCK:   state_code = MODE_PRELOCK;
         DPOMC_ST_LOCKED:    state_code = MODE_LOCKED;
         DPOMC_ST_LOSTPHASE: state_code = MODE_LOSTPHASE;
         DPOMC_ST_PRELOCK2:  state_code = MODE_PRELOCK2;
         DPOMC_ST_HOLDOVER:  state_code = MODE_HOLDOVER;
         default:            state_code = MODE_FREERUN;
      endcase
   endfunction : state_code

   assign lock_rise = ref_i.lock & ~lock_q;   // [RULE17]
   assign lock_fall = ~ref_i.lock & lock_q;   // [RULE17]

   always_ff @(posedge clk_sys_i) begin
      if (!nrst_i) begin
         lock_q <= 1'b0;
      end else begin
         lock_q <= ref_i.lock;
      end
   end

   // disqualification with nothing left beats a switch, which beats the lock level (pre-locked states) and the lock-loss edge (locked)
   always_comb begin
      next_state = state;
      case (state)
         DPOMC_ST_FREERUN: begin
            if (ref_i.selected) begin   // [RULE7] [RULE19]
               next_state = DPOMC_ST_PRELOCK;
            end
         end
         DPOMC_ST_HOLDOVER: begin
            if (ref_i.selected) begin   // [RULE19]
               next_state = DPOMC_ST_PRELOCK;
            end
         end
         DPOMC_ST_PRELOCK, DPOMC_ST_PRELOCK2, DPOMC_ST_LOSTPHASE: begin
            if (ref_i.disq_none) begin   // [RULE19]
               next_state = DPOMC_ST_HOLDOVER;
            end else if (ref_i.switched) begin   // [RULE8] [RULE19]
               next_state = DPOMC_ST_PRELOCK2;
            end else if (ref_i.lock) begin   // [RULE10] [RULE17]
               next_state = DPOMC_ST_LOCKED;
            end
         end
         DPOMC_ST_LOCKED: begin
            if (ref_i.disq_none) begin
               next_state = DPOMC_ST_HOLDOVER;
            end else if (ref_i.switched) begin
               next_state = DPOMC_ST_PRELOCK2;
            end else if (lock_fall) begin   // [RULE19]
               next_state = DPOMC_ST_LOSTPHASE;
            end
         end
         default: next_state = DPOMC_ST_FREERUN;
      endcase
   end

   // the machine keeps running under a forced mode so that auto resumes cleanly
   always_ff @(posedge clk_sys_i) begin
      if (!nrst_i) begin
         state <= DPOMC_ST_FREERUN;   // [RULE7] [RULE19]
      end else begin
         state <= next_state;
      end
   end

   always_comb begin
      case (mode_select_i)   // [RULE1] [RULE2] [RULE3]
         MODE_AUTO:      next_mode = state_code(state);
         MODE_FREERUN, MODE_HOLDOVER, MODE_LOCKED, MODE_PRELOCK2,
         MODE_PRELOCK, MODE_LOSTPHASE, MODE_OSC_FREQ, MODE_OSC_PHASE:
                         next_mode = mode_select_i;
         // reserved codes hold the current mode
         default:        next_mode = current_mode_report_o;
      endcase
   end

   always_ff @(posedge clk_sys_i) begin
      if (!nrst_i) begin
         current_mode_report_o <= MODE_FREERUN;
      end else begin
         current_mode_report_o <= next_mode;   // [RULE4]
      end
   end

   // set wins over a clear in the same cycle
   always_ff @(posedge clk_sys_i) begin
      if (!nrst_i) begin
         mode_change_flag_o <= 1'b0;
      end else if (next_mode != current_mode_report_o) begin
         mode_change_flag_o <= 1'b1;   // [RULE5] [RULE20]
      end else if (flag_clear_i) begin
         mode_change_flag_o <= 1'b0;   // [RULE20]
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (!nrst_i) begin
         irq_o <= 1'b0;
      end else begin
         irq_o <= mode_change_flag_o & irq_mask_i;   // [RULE6]
      end
   end

   // starting window restarts whenever the loop is not tracking
   always_ff @(posedge clk_sys_i) begin
      if (!nrst_i) begin
         start_cnt <= '0;
         stage_o   <= DPOMC_STG_START;
      end else if (current_mode_report_o == MODE_LOCKED) begin
         stage_o   <= DPOMC_STG_LOCK;   // [RULE14] [RULE15]
      end else if (current_mode_report_o == MODE_PRELOCK ||
                   current_mode_report_o == MODE_PRELOCK2 ||
                   current_mode_report_o == MODE_LOSTPHASE) begin
         if (start_cnt == START_CNT_W'(START_CYCLES - 1)) begin
            stage_o <= DPOMC_STG_ACQ;   // [RULE13] [RULE15]
         end else begin
            start_cnt <= start_cnt + 1'b1;   // [RULE12]
            stage_o   <= (stage_o == DPOMC_STG_LOCK) ? DPOMC_STG_ACQ : stage_o;
         end
      end else begin
         start_cnt <= '0;
         stage_o   <= DPOMC_STG_START;
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (!nrst_i) begin
         filt_o <= '0;
      end else begin
         case (stage_o)
            DPOMC_STG_START: filt_o <= start_filt_i;   // [RULE12]
            DPOMC_STG_ACQ:   filt_o <= acq_filt_i;     // [RULE13]
            default: begin
               // reserved bandwidth codes clamp to the widest defined one
               filt_o.bw   <= (lock_filt_i.bw > BW_CODE_MAX) ? BW_CODE_MAX
                                                             : lock_filt_i.bw;   // [RULE16]
               filt_o.damp <= lock_filt_i.damp;   // [RULE14]
            end
         endcase
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (!nrst_i) begin
         ctl_o <= '0;
      end else begin
         ctl_o.sys_only    <= (next_mode == MODE_FREERUN);   // [RULE9]
         ctl_o.use_stored  <= (next_mode == MODE_HOLDOVER);  // [RULE18]
         ctl_o.phase_track <= (next_mode == MODE_LOCKED) |
                              (next_mode == MODE_PRELOCK) |
                              (next_mode == MODE_PRELOCK2) |
                              (next_mode == MODE_LOSTPHASE);  // [RULE10]
         ctl_o.freq_track  <= (next_mode == MODE_LOCKED);    // [RULE11]
         ctl_o.osc_freq    <= (next_mode == MODE_OSC_FREQ);  // [RULE3]
         ctl_o.osc_phase   <= (next_mode == MODE_OSC_PHASE); // [RULE3]
      end
   end

   a_irq_follows_flag: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
      (mode_change_flag_o && irq_mask_i) |=> irq_o) else $error("irq missing"); // [RULE6]
   a_flag_on_change: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
      $changed(current_mode_report_o) |-> mode_change_flag_o)
      else $error("flag not set on change"); // [RULE5]
   a_flag_sticky: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
      (mode_change_flag_o && !flag_clear_i) |=> mode_change_flag_o)
      else $error("flag dropped"); // [RULE20]
   a_forced_mode: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
      (mode_select_i == MODE_LOCKED) [*2] |-> current_mode_report_o == MODE_LOCKED)
      else $error("forced mode not shown"); // [RULE2]
   a_freerun_forced: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
      (mode_select_i == MODE_FREERUN) [*2] |-> ctl_o.sys_only && !ctl_o.phase_track)
      else $error("free-run tracks input"); // [RULE9]
   a_auto_holdover: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
      (state == DPOMC_ST_LOCKED && ref_i.disq_none) |=> state == DPOMC_ST_HOLDOVER)
      else $error("no holdover"); // [RULE19]
   a_auto_unlock: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
      (state == DPOMC_ST_LOCKED && lock_fall && !ref_i.disq_none && !ref_i.switched)
      |=> state == DPOMC_ST_LOSTPHASE) else $error("no lost-phase"); // [RULE17]
   a_lock_stage: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
      (current_mode_report_o == MODE_LOCKED) [*2] |-> stage_o == DPOMC_STG_LOCK)
      else $error("stage not locked"); // [RULE15]
   a_start_filter: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
      (stage_o == DPOMC_STG_START) |=> filt_o == $past(start_filt_i))
      else $error("wrong start filter"); // [RULE12]

   c_auto_lock: cover property (@(posedge clk_sys_i) disable iff (!nrst_i)
      state == DPOMC_ST_PRELOCK ##1 state == DPOMC_ST_LOCKED);
   c_holdover: cover property (@(posedge clk_sys_i) disable iff (!nrst_i)
      state == DPOMC_ST_HOLDOVER);
   c_irq: cover property (@(posedge clk_sys_i) disable iff (!nrst_i) irq_o);
   c_switch: cover property (@(posedge clk_sys_i) disable iff (!nrst_i)
      state == DPOMC_ST_LOCKED ##1 state == DPOMC_ST_PRELOCK2);
   c_relock: cover property (@(posedge clk_sys_i) disable iff (!nrst_i)
      state == DPOMC_ST_LOSTPHASE && lock_rise);
endmodule : dpomc_loop

// ===== rtl/dpomc_pkg.sv
// dpomc_pkg: mode codes, status codes, stage encodings and timing for loop mode control
// assumes a 40 MHz system clock
package dpomc_pkg;
   localparam logic [4:0] MODE_AUTO      = 5'h00;
   localparam logic [4:0] MODE_FREERUN   = 5'h01;
   localparam logic [4:0] MODE_HOLDOVER  = 5'h02;
   localparam logic [4:0] MODE_LOCKED    = 5'h04;
   localparam logic [4:0] MODE_PRELOCK2  = 5'h05;
   localparam logic [4:0] MODE_PRELOCK   = 5'h06;
   localparam logic [4:0] MODE_LOSTPHASE = 5'h07;
   localparam logic [4:0] MODE_OSC_FREQ  = 5'h0A;
   localparam logic [4:0] MODE_OSC_PHASE = 5'h12;
   localparam logic [4:0] BW_CODE_MAX    = 5'h15;

   localparam int unsigned CLK_HZ        = 40000000;
   localparam int unsigned START_TIME_S  = 2;
   localparam int unsigned START_CYCLES  = START_TIME_S * CLK_HZ;
   localparam int          START_CNT_W   = 27;

   typedef enum logic [2:0] {
      DPOMC_ST_FREERUN   = 3'h0,
      DPOMC_ST_PRELOCK   = 3'h1,
      DPOMC_ST_LOCKED    = 3'h3,
      DPOMC_ST_LOSTPHASE = 3'h2,
      DPOMC_ST_PRELOCK2  = 3'h6,
      DPOMC_ST_HOLDOVER  = 3'h4
   } dpomc_state_t;

   typedef enum logic [1:0] {
      DPOMC_STG_START = 2'h0,
      DPOMC_STG_ACQ   = 2'h1,
      DPOMC_STG_LOCK  = 2'h2
   } dpomc_stage_t;

   typedef struct packed {
      logic [4:0] bw;
      logic [2:0] damp;
   } dpomc_filt_t;

   typedef struct packed {
      logic selected;
      logic disq_none;
      logic switched;
      logic lock;
   } dpomc_ref_t;

   typedef struct packed {
      logic phase_track;
      logic freq_track;
      logic use_stored;
      logic sys_only;
      logic osc_freq;
      logic osc_phase;
   } dpomc_ctl_t;
endpackage : dpomc_pkg

// ===== rtl/dpomc_top.sv
// dpomc_top: operating-mode control for loops a and b
// assumes reference selection logic runs on clk_sys_i; all control bits are plain ports
//
// Summary of operation
// RULE1: 5-bit mode field: 0 automatic, 1 forced free-run, 2 forced holdover.
// RULE2: codes 4,5,6,7 force locked, pre-locked2, pre-locked, lost-phase.
// RULE3: code 0A oscillator frequency write, 12 phase write; others reserved.
// RULE4: 5-bit status always shows the current mode, forced or automatic.
// RULE5: any mode change sets the loop's mode-change flag.
// RULE6: flag and mask both one raise the interrupt; mask resets to zero.
// RULE7: automatic machine starts at reset, reacts to select, disqualify, switch, lock.
// RULE8: switch means disqualify-and-reselect, revertive pick, or forced other input.
// RULE9: free-run uses system clock only, ignoring all references.
// RULE10: pre-locked, pre-locked2, lost-phase track the input and are transient.
// RULE11: locked follows phase and frequency of the selected reference.
// RULE12: first two seconds of a lock attempt use starting bandwidth and damping; the code sends a re-attempt after locked straight to acquisition.
// RULE13: acquisition stage uses acquisition bandwidth and damping.
// RULE14: locked stage uses locked bandwidth and damping.
// RULE15: filter stage changes happen on their own, without software.
// RULE16: locked bandwidth codes 0 to 15 hex valid; above reserved.
// RULE17: lock flag one means lock gained, zero means lock lost.
// RULE18: holdover steers from stored frequency, no phase lock to inputs.
// RULE19: reset to free-run; select, lock, unlock, loss, switch move the machine.
// RULE20: mode-change flag stays set until software clears it.
module dpomc_top
   import dpomc_pkg::*;
(
   input  wire logic        clk_sys_i,
   input  wire logic        nrst_i,
   input  wire logic [4:0]  loop_a_mode_select_i,
   input  wire logic [4:0]  loop_b_mode_select_i,
   input  wire dpomc_ref_t  ref_a_i,
   input  wire dpomc_ref_t  ref_b_i,
   input  wire dpomc_filt_t starting_a_i,
   input  wire dpomc_filt_t acquisition_a_i,
   input  wire dpomc_filt_t locked_a_i,
   input  wire dpomc_filt_t starting_b_i,
   input  wire dpomc_filt_t acquisition_b_i,
   input  wire dpomc_filt_t locked_b_i,
   input  wire logic        flag_clear_a_i,
   input  wire logic        flag_clear_b_i,
   input  wire logic        irq_mask_a_i,
   input  wire logic        irq_mask_b_i,
   output logic [4:0]       current_mode_report_a_o,
   output logic [4:0]       current_mode_report_b_o,
   output logic             mode_change_flag_a_o,
   output logic             mode_change_flag_b_o,
   output logic             irq_a_o,
   output logic             irq_b_o,
   output dpomc_stage_t     stage_a_o,
   output dpomc_stage_t     stage_b_o,
   output dpomc_filt_t      filt_a_o,
   output dpomc_filt_t      filt_b_o,
   output dpomc_ctl_t       ctl_a_o,
   output dpomc_ctl_t       ctl_b_o
);
   // both loops are identical and independent
   dpomc_loop u_loop_a (
      .clk_sys_i             (clk_sys_i),
      .nrst_i                (nrst_i),
      .mode_select_i         (loop_a_mode_select_i),
      .ref_i                 (ref_a_i),
      .start_filt_i          (starting_a_i),
      .acq_filt_i            (acquisition_a_i),
      .lock_filt_i           (locked_a_i),
      .flag_clear_i          (flag_clear_a_i),
      .irq_mask_i            (irq_mask_a_i),
      .current_mode_report_o (current_mode_report_a_o),
      .mode_change_flag_o    (mode_change_flag_a_o),
      .irq_o                 (irq_a_o),
      .stage_o               (stage_a_o),
      .filt_o                (filt_a_o),
      .ctl_o                 (ctl_a_o)
   );
   dpomc_loop u_loop_b (
      .clk_sys_i             (clk_sys_i),
      .nrst_i                (nrst_i),
      .mode_select_i         (loop_b_mode_select_i),
      .ref_i                 (ref_b_i),
      .start_filt_i          (starting_b_i),
      .acq_filt_i            (acquisition_b_i),
      .lock_filt_i           (locked_b_i),
      .flag_clear_i          (flag_clear_b_i),
      .irq_mask_i            (irq_mask_b_i),
      .current_mode_report_o (current_mode_report_b_o),
      .mode_change_flag_o    (mode_change_flag_b_o),
      .irq_o                 (irq_b_o),
      .stage_o               (stage_b_o),
      .filt_o                (filt_b_o),
      .ctl_o                 (ctl_b_o)
   );
endmodule : dpomc_top

// ===== tb/dpomc_ref_model.sv
// dpomc_ref_model: reference selection and qualification logic facing one loop
// assumes commands from the bench arrive one cycle long, synchronous to clk_sys_i
module dpomc_ref_model
   import dpomc_pkg::*;
(
   input  wire logic       clk_sys_i,
   input  wire logic       nrst_i,
   input  wire logic [2:0] cmd_i,
   output dpomc_ref_t      ref_o
);
   timeunit 1ns;
   timeprecision 100ps;
   // cmd: 1 select, 2 all disqualified, 3 switch, 4 lock, 5 unlock
   always_ff @(posedge clk_sys_i) begin
      if (!nrst_i) begin
         ref_o <= '0;
      end else begin
         ref_o.selected  <= (cmd_i == 3'h1);
         ref_o.disq_none <= (cmd_i == 3'h2);
         ref_o.switched  <= (cmd_i == 3'h3);
         // a lost or newly switched input is never reported as locked
         if (cmd_i == 3'h4) begin
            ref_o.lock <= 1'b1;
         end else if (cmd_i == 3'h5 || cmd_i == 3'h2 || cmd_i == 3'h3) begin
            ref_o.lock <= 1'b0;
         end
      end
   end
endmodule : dpomc_ref_model

// ===== tb/test_dpomc_top.sv
// test_dpomc_top: self-checking bench, forced modes on loop a, automatic walk on loop b
// assumes one 40 MHz clock and the registered latencies of the loop design
module test_dpomc_top;
   timeunit 1ns;
   timeprecision 100ps;
   import dpomc_pkg::*;
   logic clk_sys_i = 1'b0;
   logic nrst_i = 1'b0;
   logic [4:0] mode_a = 5'h00, mode_b = 5'h00;
   logic [2:0] cmd_a = 3'h0, cmd_b = 3'h0;
   logic clr_a = 1'b0, clr_b = 1'b0, mask_a = 1'b0, mask_b = 1'b0;
   dpomc_ref_t ref_a, ref_b;
   dpomc_filt_t st_f = {5'h03, 3'h1}, aq_f = {5'h07, 3'h2}, lk_f = {5'h1F, 3'h5};
   logic [4:0] rep_a, rep_b;
   logic flag_a, flag_b, irq_a, irq_b;
   dpomc_stage_t stg_a, stg_b;
   dpomc_filt_t filt_a, filt_b;
   dpomc_ctl_t ctl_a, ctl_b;
   int err_total = 0, cmp_count = 0, cycles = 0;
   typedef struct { logic [4:0] code; logic [5:0] ctl; logic [5:0] msk; } dpomc_row_t;
   dpomc_row_t rows[8] = '{'{5'h02, 6'h08, 6'h2C}, '{5'h04, 6'h30, 6'h30}, '{5'h05, 6'h20, 6'h24},
                           '{5'h06, 6'h20, 6'h24}, '{5'h07, 6'h20, 6'h24}, '{5'h0A, 6'h02, 6'h02},
                           '{5'h12, 6'h01, 6'h01}, '{5'h01, 6'h04, 6'h24}};

   always #12.5 clk_sys_i = ~clk_sys_i;

   dpomc_ref_model ref_model_a (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i),
                                .cmd_i(cmd_a), .ref_o(ref_a));
   dpomc_ref_model ref_model_b (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i),
                                .cmd_i(cmd_b), .ref_o(ref_b));

   dpomc_top dut (
      .clk_sys_i(clk_sys_i), .nrst_i(nrst_i),
      .loop_a_mode_select_i(mode_a), .loop_b_mode_select_i(mode_b),
      .ref_a_i(ref_a), .ref_b_i(ref_b),
      .starting_a_i(st_f), .acquisition_a_i(aq_f), .locked_a_i(lk_f),
      .starting_b_i(st_f), .acquisition_b_i(aq_f), .locked_b_i(lk_f),
      .flag_clear_a_i(clr_a), .flag_clear_b_i(clr_b),
      .irq_mask_a_i(mask_a), .irq_mask_b_i(mask_b),
      .current_mode_report_a_o(rep_a), .current_mode_report_b_o(rep_b),
      .mode_change_flag_a_o(flag_a), .mode_change_flag_b_o(flag_b),
      .irq_a_o(irq_a), .irq_b_o(irq_b),
      .stage_a_o(stg_a), .stage_b_o(stg_b),
      .filt_a_o(filt_a), .filt_b_o(filt_b),
      .ctl_a_o(ctl_a), .ctl_b_o(ctl_b)
   );

   task automatic cyc(input int n);
      repeat (n) @(posedge clk_sys_i);
      #1;
   endtask : cyc

   task automatic chk_vec(input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp) begin
         err_total++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk_vec

   task automatic chk_bit(input logic got, input logic exp);
      chk_vec({7'h00, got}, {7'h00, exp});
   endtask : chk_bit

   // events last one cycle; the model turns select, disqualify and switch into one-cycle strobes and lock, unlock into a held lock level
   task automatic event_b(input logic [2:0] c);
      cmd_b = c;
      cyc(1);
      cmd_b = 3'h0;
   endtask : event_b

   // bounded wait: a mode that never shows up is caught by the compare
   task automatic wait_b(input logic [4:0] exp);
      for (int i = 0; i < 8 && rep_b !== exp; i++) cyc(1);
      chk_vec({3'h0, rep_b}, {3'h0, exp});
   endtask : wait_b

   task automatic finish_test;
      $display("comparisons %0d mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : finish_test

   always @(posedge clk_sys_i) begin
      cycles++;
      if (cycles > 3000) begin
         err_total++;
         finish_test;
      end
   end

   initial begin
      cyc(2);
      chk_vec({3'h0, rep_a}, {3'h0, MODE_FREERUN});
      chk_bit(flag_a, 1'b0);
      chk_bit(irq_a, 1'b0);
      nrst_i = 1'b1;
      cyc(3);
      $display("test reset done");
      foreach (rows[i]) begin
         mode_a = rows[i].code;
         cyc(3);
         chk_vec({3'h0, rep_a}, {3'h0, rows[i].code});
         chk_vec({2'h0, ctl_a & rows[i].msk}, {2'h0, rows[i].ctl});
         chk_bit(flag_a, 1'b1);
         chk_bit(irq_a, 1'b0);
         clr_a = 1'b1;
         cyc(1);
         clr_a = 1'b0;
         cyc(2);
         chk_bit(flag_a, 1'b0);
      end
      $display("test forced modes done");
      mode_a = 5'h03;
      cyc(3);
      mode_a = 5'h1F;
      cyc(3);
      chk_vec({3'h0, rep_a}, {3'h0, MODE_FREERUN});
      chk_bit(flag_a, 1'b0);
      chk_vec({6'h00, stg_a}, {6'h00, DPOMC_STG_START});
      chk_vec(filt_a, st_f);
      $display("test reserved codes done");
      event_b(3'h1);
      wait_b(MODE_PRELOCK);
      cyc(2);
      chk_vec({6'h00, stg_b}, {6'h00, DPOMC_STG_START});
      chk_vec(filt_b, st_f);
      chk_vec({2'h0, ctl_b}, 8'h20);
      chk_bit(irq_b, 1'b0);
      mask_b = 1'b1;
      cyc(2);
      chk_bit(irq_b, 1'b1);
      cyc(5);
      chk_bit(flag_b, 1'b1);
      clr_b = 1'b1;
      cyc(1);
      clr_b = 1'b0;
      cyc(2);
      chk_bit(irq_b, 1'b0);
      event_b(3'h4);
      wait_b(MODE_LOCKED);
      cyc(3);
      chk_vec({6'h00, stg_b}, {6'h00, DPOMC_STG_LOCK});
      chk_vec(filt_b, {BW_CODE_MAX, lk_f.damp});
      chk_vec({2'h0, ctl_b}, 8'h30);
      chk_bit(flag_b, 1'b1);
      event_b(3'h5);
      wait_b(MODE_LOSTPHASE);
      event_b(3'h4);
      wait_b(MODE_LOCKED);
      event_b(3'h3);
      wait_b(MODE_PRELOCK2);
      event_b(3'h4);
      wait_b(MODE_LOCKED);
      event_b(3'h2);
      wait_b(MODE_HOLDOVER);
      cyc(3);
      chk_vec({3'h0, rep_b}, {3'h0, MODE_HOLDOVER});
      chk_vec({2'h0, ctl_b}, 8'h08);
      event_b(3'h1);
      wait_b(MODE_PRELOCK);
      cyc(2);
      chk_vec({6'h00, stg_b}, {6'h00, DPOMC_STG_START});
      $display("test automatic walk done");
      // second reset with the flag and interrupt of loop b pending
      nrst_i = 1'b0;
      cyc(2);
      chk_vec({3'h0, rep_b}, {3'h0, MODE_FREERUN});
      chk_bit(flag_b, 1'b0);
      chk_bit(irq_b, 1'b0);
      chk_vec(filt_b, 8'h00);
      nrst_i = 1'b1;
      cyc(3);
      chk_vec(filt_b, st_f);
      chk_vec({2'h0, ctl_b}, 8'h04);
      chk_bit(flag_b, 1'b0);
      $display("test mid-run reset done");
      finish_test;
   end
endmodule : test_dpomc_top
